//--- core/sensor_param_regs.svh
// Bit positions, codes and reset values of the sensor parameter word
`ifndef SENSOR_PARAM_REGS_SVH
`define SENSOR_PARAM_REGS_SVH

// ==========================================
// Word geometry
`define PARAM_WORD_W      16
`define PARAM_RESET       16'h0000
`define PARAM_FULL_RES    16'h823E

// ==========================================
// Field positions
`define BIT_ARRAY_PWR     1
`define BIT_AMP4_PWR      2
`define BIT_AMP1_PWR      5
`define BIT_COL_LO        6
`define BIT_COL_HI        8
`define BIT_ROW_LO        9
`define BIT_ROW_HI        11
`define BIT_XBAR_INIT     12
`define BIT_XBAR_TOGGLE   13
`define BIT_ARRAY_PWR2    15

// ==========================================
// Subsampling codes
`define COL_CODE_S4K20    3'h3
`define COL_CODE_S4K4     3'h4
`define COL_CODE_S4K8     3'h5
`define ROW_CODE_FULL     3'h1

// ==========================================
// Synchroniser warm-up: cycles before edges count
`define WARM_DONE         2'h3

`endif

//--- core/sensor_param_pkg.sv
// Types shared by the sensor parameter register
package sensor_param_pkg;

  // ==========================================
  // Column subsampling modes
  typedef enum logic [1:0] {
    COL_FULL,
    COL_S4K20,
    COL_S4K4,
    COL_S4K8
  } col_mode_t;

  // ==========================================
  // Pins from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic cs_n;
    logic row_clk;
    logic row_sync_n;
  } pin_t;

  // Source bus index (0 = bus 1) for each output amplifier
  typedef struct packed {
    logic [1:0] out4;
    logic [1:0] out3;
    logic [1:0] out2;
    logic [1:0] out1;
  } route_t;

  // ==========================================
  // Whole state of the register block
  typedef struct packed {
    pin_t        s1;
    pin_t        s2;
    pin_t        s3;
    logic [1:0]  warm;
    logic [15:0] shift;
    logic [15:0] param;
    logic        loaded;
    logic        xbar;
    logic        array_pwr;
    logic [3:0]  amp_pwr;
    col_mode_t   col_mode;
    logic [2:0]  row_code;
    logic        row_full;
    route_t      route;
  } state_t;

endpackage : sensor_param_pkg

//--- core/sensor_serial_param_register.sv
// Serial-loaded sensor parameter register with output crossbar control
//
// What this block does
// - Sample serial data at each rising serial clock; first bit lands in bit 0.
// - Controller sets data before the clock edge; device shifts it in then.
// - Rising chip select copies the shifted word to the parameter register.
// - The word is sixteen bits; all are shifted before chip select rises.
// - Register content is undefined after power-up until a word is loaded; here reset loads 16'h0000.
// - Bit 1 powers the pixel array on when one, down when zero.
// - Bits 2 to 5 power amplifiers 4, 3, 2, 1 individually.
// - Bits 6 to 8 pick column subsampling; 011, 100, 101 skip modes.
// - Bits 9 to 11 pick row subsampling; 001 is full resolution.
// - Bit 12 is the crossbar initial value, loaded on the row sync.
// - Crossbar at 0 maps bus 1,2 to out 1,2; at 1 swapped.
// - Bit 13 set toggles the crossbar bit on each rising row clock edge with row sync high.
// - Bit 15 must also be one for the pixel array to power on, alongside bit 1.
// - Low row sync at a row clock rising edge loads the crossbar from bit 12.
`include "sensor_param_regs.svh"

module sensor_serial_param_register (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // Serial parameter link
  input  wire logic                       ser_clk,
  input  wire logic                       ser_data,
  input  wire logic                       ser_cs_n,
  // Switchboard row timing
  input  wire logic                       row_clk,
  input  wire logic                       row_sync_n,
  // Power controls
  output logic                            array_power_on,
  output logic [3:0]                      amp_power_on,
  // Subsampling controls
  output sensor_param_pkg::col_mode_t     col_mode,
  output logic [2:0]                      row_mode_code,
  output logic                            row_full_res,
  // Crossbar
  output logic                            crossbar_sel,
  output sensor_param_pkg::route_t        out_route,
  // Register view
  output logic [`PARAM_WORD_W-1:0]        param_word,
  output logic                            param_valid
);

  // ==========================================
  // State
  sensor_param_pkg::state_t st_r;
  sensor_param_pkg::state_t st_nxt;
  sensor_param_pkg::pin_t   pins;

  logic       armed;
  logic       sclk_rise;
  logic       cs_rise;
  logic       row_rise;
  logic [3:0] amp_map;
  logic [15:0] param_nxt;

  // Pin bundle into the first synchroniser stage
  assign pins = '{sclk:       ser_clk,
                  sdata:      ser_data,
                  cs_n:       ser_cs_n,
                  row_clk:    row_clk,
                  row_sync_n: row_sync_n};

  // ==========================================
  // Edge finding on the second and third stages
  // Edges are held off until the stages hold real pin levels,
  // otherwise a pin idling high would fake a rising edge.
  assign armed     = (st_r.warm == `WARM_DONE);
  assign sclk_rise = armed & st_r.s2.sclk & ~st_r.s3.sclk;
  assign cs_rise   = armed & st_r.s2.cs_n & ~st_r.s3.cs_n;
  assign row_rise  = armed & st_r.s2.row_clk & ~st_r.s3.row_clk;

  // ==========================================
  // Word as it stands after this edge; amplifier enables decode from here, not from
  // st_nxt, so the enables form no loop through the next-state block
  assign param_nxt = cs_rise ? st_r.shift : st_r.param;

  // ==========================================
  // Amplifier enables; bit order runs opposite to amp number
  for (genvar i = 0; i < 4; i++) begin : g_amp
    assign amp_map[i] = param_nxt[`BIT_AMP1_PWR - i];
  end

  // ==========================================
  // Next state
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (!armed) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end

    // Data is taken from the same stage as the clock edge, so both
    // see the same two-cycle delay and setup at the pins carries over
    if (sclk_rise) begin
      st_nxt.shift = {st_r.s2.sdata, st_r.shift[15:1]};
    end

    // Settings change only here; a late clock edge in the same cycle
    // is not part of the loaded word
    if (cs_rise) begin
      st_nxt.param  = st_r.shift;
      st_nxt.loaded = 1'b1;
    end

    // Switchboard: sync wins over toggle
    if (row_rise) begin
      if (!st_r.s2.row_sync_n) begin
        st_nxt.xbar = st_r.param[`BIT_XBAR_INIT];
      end else if (st_r.param[`BIT_XBAR_TOGGLE]) begin
        st_nxt.xbar = ~st_r.xbar;
      end
    end

    // Decoded controls follow the new word in the same edge
    st_nxt.array_pwr = st_nxt.param[`BIT_ARRAY_PWR]
                     & st_nxt.param[`BIT_ARRAY_PWR2];
    st_nxt.amp_pwr   = amp_map;

    // Codes 000, 001, 010, 110 and 111 all read as full resolution
    unique case (st_nxt.param[`BIT_COL_HI:`BIT_COL_LO])
      `COL_CODE_S4K20: st_nxt.col_mode = sensor_param_pkg::COL_S4K20;
      `COL_CODE_S4K4:  st_nxt.col_mode = sensor_param_pkg::COL_S4K4;
      `COL_CODE_S4K8:  st_nxt.col_mode = sensor_param_pkg::COL_S4K8;
      default:         st_nxt.col_mode = sensor_param_pkg::COL_FULL;
    endcase

    // Row patterns other than full are passed on raw
    st_nxt.row_code = st_nxt.param[`BIT_ROW_HI:`BIT_ROW_LO];
    st_nxt.row_full = (st_nxt.row_code == `ROW_CODE_FULL);

    // Crossbar swaps buses 1 and 2 only; 3 and 4 stay fixed
    st_nxt.route.out1 = st_nxt.xbar ? 2'h1 : 2'h0;
    st_nxt.route.out2 = st_nxt.xbar ? 2'h0 : 2'h1;
    st_nxt.route.out3 = 2'h2;
    st_nxt.route.out4 = 2'h3;

    // The word has no meaningful reset value; zero keeps every
    // amplifier and the array powered down until the first load
    if (!resetn) begin
      st_nxt          = '0;
      st_nxt.param    = `PARAM_RESET;
      st_nxt.route    = '{out4: 2'h3, out3: 2'h2, out2: 2'h1, out1: 2'h0};
      st_nxt.col_mode = sensor_param_pkg::COL_FULL;
    end
  end

  // ==========================================
  // Single state register
  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  // ==========================================
  // Outputs straight from the state register
  assign array_power_on = st_r.array_pwr;
  assign amp_power_on   = st_r.amp_pwr;
  assign col_mode       = st_r.col_mode;
  assign row_mode_code  = st_r.row_code;
  assign row_full_res   = st_r.row_full;
  assign crossbar_sel   = st_r.xbar;
  assign out_route      = st_r.route;
  assign param_word     = st_r.param;
  assign param_valid    = st_r.loaded;

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_sclk_edge;
    sclk_rise;
  endsequence

  sequence seq_row_sync;
    row_rise && !st_r.s2.row_sync_n;
  endsequence

  sequence seq_row_step;
    row_rise && st_r.s2.row_sync_n && st_r.param[`BIT_XBAR_TOGGLE];
  endsequence

  a_shift_lsb_first: assert property (
    seq_sclk_edge |=> st_r.shift[15] == $past(st_r.s2.sdata)
                      && st_r.shift[14:0] == $past(st_r.shift[15:1]))
    else $error("serial bit not shifted in at the top");

  a_shift_idle_hold: assert property (
    !sclk_rise |=> $stable(st_r.shift))
    else $error("shift chain moved without a clock edge");

  a_pin_to_shift: assert property (
    armed && $rose(st_r.s2.sclk) |=> st_r.shift[15] == $past(st_r.s2.sdata)
      && st_r.shift[14:0] == $past(st_r.shift[15:1]))
    else $error("serial edge lost in synchroniser");

  a_cs_load_word: assert property (
    cs_rise |=> param_word == $past(st_r.shift) && param_valid)
    else $error("word not loaded on chip select rise");

  a_param_hold: assert property (
    !cs_rise |=> $stable(param_word))
    else $error("parameter word changed without chip select rise");

  a_array_power: assert property (
    array_power_on == (param_word[`BIT_ARRAY_PWR]
                       && param_word[`BIT_ARRAY_PWR2]))
    else $error("array power does not follow bits 1 and 15");

  a_amp_power: assert property (
    amp_power_on == {param_word[2], param_word[3],
                     param_word[4], param_word[5]})
    else $error("amplifier power bits out of order");

  a_col_mode_map: assert property (
    param_word[8:6] == 3'h3 |-> col_mode == sensor_param_pkg::COL_S4K20)
    else $error("column code 011 not decoded");

  a_row_full_map: assert property (
    row_full_res == (param_word[11:9] == 3'h1))
    else $error("row full resolution flag wrong");

  a_xbar_sync: assert property (
    seq_row_sync |=> crossbar_sel == $past(param_word[12]))
    else $error("crossbar not reloaded on row sync");

  a_xbar_toggle: assert property (
    seq_row_step |=> crossbar_sel != $past(crossbar_sel))
    else $error("crossbar did not toggle on row clock");

  a_xbar_still: assert property (
    !row_rise |=> $stable(crossbar_sel))
    else $error("crossbar changed between row clock edges");

  a_xbar_route: assert property (
    out_route.out1 == {1'b0, crossbar_sel}
    && out_route.out2 == {1'b0, !crossbar_sel}
    && out_route.out3 == 2'h2 && out_route.out4 == 2'h3)
    else $error("crossbar routing wrong");

  // ==========================================
  // Decode and load checks
  // Decodes are held against the word itself, so a wrong field
  // position shows up here even where the bench never looks
  sequence seq_cs_edge;
    cs_rise;
  endsequence

  sequence seq_row_plain;
    row_rise && st_r.s2.row_sync_n && !st_r.param[`BIT_XBAR_TOGGLE];
  endsequence

  a_col_s4k4_map: assert property (
    param_word[8:6] == 3'h4 |-> col_mode == sensor_param_pkg::COL_S4K4)
    else $error("column code 100 not decoded");

  a_col_s4k8_map: assert property (
    param_word[8:6] == 3'h5 |-> col_mode == sensor_param_pkg::COL_S4K8)
    else $error("column code 101 not decoded");

  a_col_full_map: assert property (
    param_word[8:6] inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7}
      |-> col_mode == sensor_param_pkg::COL_FULL)
    else $error("column full resolution code not decoded");

  a_row_code_raw: assert property (
    row_mode_code == param_word[11:9])
    else $error("row code not passed on");

  a_valid_sticky: assert property (
    param_valid |=> param_valid)
    else $error("loaded flag dropped without reset");

  a_valid_rise: assert property (
    $rose(param_valid) |-> $past(cs_rise))
    else $error("loaded flag rose without chip select");

  a_cs_new_power: assert property (
    seq_cs_edge |=> array_power_on == ($past(st_r.shift[`BIT_ARRAY_PWR])
                                       && $past(st_r.shift[`BIT_ARRAY_PWR2])))
    else $error("power setting not applied on chip select rise");

  a_cs_new_amps: assert property (
    seq_cs_edge |=> amp_power_on == {$past(st_r.shift[2]), $past(st_r.shift[3]),
                                     $past(st_r.shift[4]), $past(st_r.shift[5])})
    else $error("amplifier setting not applied on chip select rise");

  a_cs_new_rows: assert property (
    seq_cs_edge |=> row_mode_code == $past(st_r.shift[11:9]))
    else $error("row setting not applied on chip select rise");

  a_xbar_no_toggle: assert property (
    seq_row_plain |=> $stable(crossbar_sel))
    else $error("crossbar toggled with toggling off");

endmodule : sensor_serial_param_register

//--- verification/serial_ctl_model.sv
// Camera controller model driving the serial parameter link
module serial_ctl_model (
  // Pacing clock
  input  wire logic ref_clk,
  // Serial link pins
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_cs_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Link idle: clock low, not selected
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_cs_n = 1'b1;
  end

  // ==========================================
  // One frame, 80 ns link clock, still outside frames
  task automatic send(input logic [15:0] w, input logic load);
    logic [15:0] v;
    v = w & 16'hBFFE;  // Spare bits kept zero
    @(negedge ref_clk);
    ser_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin  // Whole word, first bit lowest
      ser_data = v[i];  // Set up well ahead of the rise
      repeat (4) @(negedge ref_clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge ref_clk);
      ser_clk = 1'b0;
    end
    // Released data must not look like the last bit
    ser_data = ~v[15];
    repeat (2) @(negedge ref_clk);
    if (load) ser_cs_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask : send
endmodule : serial_ctl_model

//--- verification/sensor_serial_param_register_tb.sv
// Self-checking bench for the serial sensor parameter register
module sensor_serial_param_register_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // Signals
  logic                        ref_clk, resetn, row_clk, row_sync_n;
  logic                        ser_clk, ser_data, ser_cs_n;
  logic                        array_power_on, row_full_res, crossbar_sel, param_valid;
  logic [3:0]                  amp_power_on;
  logic [2:0]                  row_mode_code;
  logic [15:0]                 param_word, last_w;
  sensor_param_pkg::col_mode_t col_mode;
  sensor_param_pkg::route_t    out_route;
  int                          n_mismatch = 0;
  int                          total_checks = 0;

  sensor_serial_param_register u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_cs_n(ser_cs_n), .row_clk(row_clk), .row_sync_n(row_sync_n),
    .array_power_on(array_power_on), .amp_power_on(amp_power_on), .col_mode(col_mode),
    .row_mode_code(row_mode_code), .row_full_res(row_full_res),
    .crossbar_sel(crossbar_sel), .out_route(out_route), .param_word(param_word),
    .param_valid(param_valid)
  );

  serial_ctl_model u_ctl (
    .ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n)
  );

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // ==========================================
  // Compare, verdict and expectations
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  function automatic sensor_param_pkg::col_mode_t col_exp(input logic [2:0] c);
    case (c)
      3'h3: return sensor_param_pkg::COL_S4K20;
      3'h4: return sensor_param_pkg::COL_S4K4;
      3'h5: return sensor_param_pkg::COL_S4K8;
      default: return sensor_param_pkg::COL_FULL;
    endcase
  endfunction : col_exp

  // All decodes of a freshly loaded word
  task automatic chk_word(input logic [15:0] w);
    last_w = w & 16'hBFFE;
    chk(param_word, last_w, "word");
    chk(16'(param_valid), 16'h0001, "valid");
    chk(16'(array_power_on), 16'(last_w[1] & last_w[15]), "array");
    chk(16'(amp_power_on), 16'({last_w[2], last_w[3], last_w[4], last_w[5]}), "amps");
    chk(16'(col_mode), 16'(col_exp(last_w[8:6])), "col");
    chk(16'(row_mode_code), 16'(last_w[11:9]), "row code");
    chk(16'(row_full_res), 16'(last_w[11:9] == 3'h1), "row full");
  endtask : chk_word

  // One row clock rise, sync low or high
  task automatic row_pulse(input logic sync_n);
    @(negedge ref_clk);
    row_sync_n = sync_n;
    repeat (3) @(negedge ref_clk);
    row_clk = 1'b1;
    repeat (4) @(negedge ref_clk);
    row_clk = 1'b0;
    row_sync_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask : row_pulse

  task automatic chk_xbar(input logic sel);
    chk(16'(crossbar_sel), 16'(sel), "xbar");
    chk(16'(out_route), sel ? 16'h00E1 : 16'h00E4, "route");
  endtask : chk_xbar

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk(16'(param_valid), 16'h0000, "valid at reset");
    chk(param_word, 16'h0000, "word at reset");
    chk_xbar(1'b0);
  endtask : t_reset

  // Every column and row code, walking amplifier bit
  task automatic t_codes();
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {4'h8, 3'(i), 3'(i), 4'(1 << (i % 4)), 1'(i), 1'b0};
      u_ctl.send(w, 1'b1);
      chk_word(w);
    end
  endtask : t_codes

  // Shift without select rise keeps old settings
  task automatic t_no_load();
    u_ctl.send(16'hFFFF, 1'b0);
    chk(param_word, last_w, "no load");
    u_ctl.send(16'h0002, 1'b1);
    chk_word(16'h0002);
  endtask : t_no_load

  // Initial value, hold, toggle, sync over toggle
  task automatic t_xbar();
    u_ctl.send(16'h923E, 1'b1);
    row_pulse(1'b0);
    chk_xbar(1'b1);
    row_pulse(1'b1);
    chk_xbar(1'b1);
    u_ctl.send(16'hB23E, 1'b1);
    row_pulse(1'b1);
    chk_xbar(1'b0);
    row_pulse(1'b1);
    chk_xbar(1'b1);
    // Toggle alone would give 0 here, so only the sync explains a 1
    row_pulse(1'b0);
    chk_xbar(1'b1);
    // Initial value 0 must also load, with toggling off
    u_ctl.send(16'h823E, 1'b1);
    row_pulse(1'b0);
    chk_xbar(1'b0);
  endtask : t_xbar

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    row_clk = 1'b0;
    row_sync_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    u_ctl.send(16'h823E, 1'b1);
    chk_word(16'h823E);
    t_codes();
    t_no_load();
    t_xbar();
    // Reset again mid-run: loaded word and crossbar must clear
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    conclude();
  end

  // Hang guard
  initial begin
    #500us;
    n_mismatch++;
    conclude();
  end
endmodule : sensor_serial_param_register_tb
